// ===== hdl/tca_defs.svh
// Register offsets, field positions and fixed values of the transfer controller
`ifndef TCA_DEFS_SVH
`define TCA_DEFS_SVH
// ----------------------------------------------------------------
// Register map (byte addresses on the APB)
// ----------------------------------------------------------------
`define TCA_OFS_BLKLEN 8'h00
`define TCA_OFS_EN0 8'h04
`define TCA_OFS_EN4 8'h14
`define TCA_OFS_CSR 8'h18
`define TCA_OFS_BASE 8'h1c
`define TCA_OFS_STAT 8'h20
`define TCA_EN_REGS 5
`define TCA_NSRC 40
`define TCA_SRC_SOFT 6'h28
// ----------------------------------------------------------------
// Control/status word fields
// ----------------------------------------------------------------
`define TCA_CSR_NMI 10
`define TCA_CSR_AE 9
`define TCA_CSR_SWE 8
`define TCA_CSR_VEC 7:0
`define TCA_CSR_RST 16'h0000
`define TCA_EN_RST 40'h00_0000_0000
// ----------------------------------------------------------------
// Descriptor mode word fields and codes
// ----------------------------------------------------------------
`define TCA_M_SM 15:14
`define TCA_M_DM 13:12
`define TCA_M_MD 11:10
`define TCA_M_SZ 9:8
`define TCA_M_DTS 7
`define TCA_M_CHAIN_ENABLE 6
`define TCA_M_INTERRUPT_SELECT 5
`define TCA_M_NMI_CONTINUE_MODE 4
`define TCA_MD_REPEAT 2'h1
`define TCA_MD_BLOCK 2'h2
`define TCA_SZ_BYTE 2'h0
`define TCA_SZ_WORD 2'h1
`define TCA_SZ_LONG 2'h2
// ----------------------------------------------------------------
// Addresses, steps and counts
// ----------------------------------------------------------------
`define TCA_VEC_BASE 16'h0400
`define TCA_CHAIN_STEP 32'h0000_0010
`define TCA_DESC_LAST 2'h3
`define TCA_WB_LAST 2'h2
`define TCA_LEN_FULL 17'h1_0000
`endif

// ===== hdl/tca_pkg.sv
// Types shared by the transfer controller
package tca_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_VEC,
    ST_DESC,
    ST_RD,
    ST_WR,
    ST_WB
  } tca_state_e;
endpackage

// ===== hdl/tca_top.sv
// Transfer controller activation, register file and descriptor engine
//
// How it works
// RL1: Block length zero means 65536 units
// RL2: Five enable registers, one bit per source
// RL3: Enables clear on power-on and standby only
// RL4: Enable bit changes only against its read value
// RL5: Control word clears on power-on and standby
// RL6: Top five control bits read zero
// RL7: NMI flag blocks starts, read-one-write-zero clear
// RL8: NMI continue mode finishes current transfer
// RL9: Address error flag blocks all transfers
// RL10: Soft enable: set always, clear after read
// RL11: Soft vector writable only while disabled
// RL12: Soft vector address is 0x0400 plus vector
// RL13: Base register written as whole word only
// RL14: Base register has no reset at all
// RL15: Read descriptor, move data, write back
// RL16: Chain enable continues with next descriptor
// RL17: Normal, repeat, block modes; address stepping
// RL18: Interrupt select: every transfer or count end
// RL19: Passing interrupt clears that source enable
// RL20: Soft enable clears unless interrupt raised
// RL21: Simultaneous requests served by fixed priority
// RL22: Vector table two bytes per source
// RL23: Descriptor address is base plus vector entry
// RL24: NMI aborts transfer without continue mode
// RL25: Out-of-sequence writes leave bits unchanged
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
module tca_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [39:0] src_req,
  input wire logic nmi_event,
  input wire logic standby,
  input wire logic manual_reset,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  output logic cpu_irq,
  output logic [5:0] cpu_irq_src,
  output logic busy
);
`include "tca_defs.svh"

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Address step after one unit, per size and hold/inc/dec mode
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] m,
                                            input logic [1:0] sz);
    logic [31:0] inc;
    inc = (sz == `TCA_SZ_BYTE) ? 32'h1 : (sz == `TCA_SZ_WORD) ? 32'h2 : 32'h4;
    if (!m[1]) begin
      step_addr = a;
    end else if (m[0]) begin
      step_addr = a - inc;
    end else begin
      step_addr = a + inc;
    end
  endfunction

  // Highest priority pending source: lowest index wins
  function automatic logic [6:0] pick(input logic [39:0] p);
    pick = 7'h00;
    for (int i = `TCA_NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        pick = {1'b1, 6'(i)};
      end
    end
  endfunction

  // RL2: source i is register i/8, bit 7 - i%8
  function automatic int en_bit(input int i);
    en_bit = (i / 8) * 8 + 7 - (i % 8);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] blklen_r, blklen_nxt;
  logic [39:0] en_r, en_nxt;
  logic [39:0] snap_r, snap_nxt;
  logic [4:0] arm_r, arm_nxt;
  logic nmi_flag_r, nmi_flag_nxt, ae_r, ae_nxt, swe_r, swe_nxt;
  logic [7:0] svec_r, svec_nxt;
  logic [2:0] csnap_r, csnap_nxt;
  logic carm_r, carm_nxt;
  logic [15:0] base_r, base_nxt;
  logic stby_q_r, soft_pend_r, soft_pend_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;

  tca_pkg::tca_state_e st_r, st_nxt;
  logic [5:0] src_r, src_nxt;
  logic [31:0] dsc_r, dsc_nxt, sar_r, sar_nxt, dar_r, dar_nxt, iar_r, iar_nxt;
  logic [31:0] bst_r, bst_nxt;
  logic [15:0] mw_r, mw_nxt, cnt_r, cnt_nxt;
  logic [16:0] left_r, left_nxt;
  logic [1:0] wi_r, wi_nxt;
  logic done_r, done_nxt, stop_r, stop_nxt;
  logic [39:0] pend_r, pend_nxt;
  logic mem_req_nxt, mem_we_nxt, cpu_irq_nxt, busy_nxt;
  logic [1:0] mem_size_nxt;
  logic [31:0] mem_addr_nxt, mem_wdata_nxt;
  logic [5:0] cpu_irq_src_nxt;

  // Engine events toward the register file
  logic [39:0] ev_clr_en;
  logic ev_clr_swe, ev_set_ae, ev_soft_taken;

  // APB access completes on the edge where pready is seen high
  logic acc, wr_acc, rd_acc, stby_entry, full_word;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign stby_entry = standby && !stby_q_r;
  assign full_word = pstrb[0] && pstrb[1];

  // ----------------------------------------------------------------
  // APB slave and register file
  // ----------------------------------------------------------------
  // One wait state keeps prdata and pready straight from flops
  always_comb begin
    int k;
    logic [7:0] rv, wv;
    k = 0;
    rv = 8'h00;
    wv = 8'h00;
    blklen_nxt = blklen_r;
    en_nxt = en_r;
    snap_nxt = snap_r;
    arm_nxt = arm_r;
    nmi_flag_nxt = nmi_flag_r;
    ae_nxt = ae_r;
    swe_nxt = swe_r;
    svec_nxt = svec_r;
    csnap_nxt = csnap_r;
    carm_nxt = carm_r;
    base_nxt = base_r;
    soft_pend_nxt = soft_pend_r && !ev_soft_taken;
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    // Read data and error are prepared for the completing edge
    if (psel && penable && !pready) begin
      if (paddr == `TCA_OFS_BLKLEN) begin
        prdata_nxt = {16'h0000, blklen_r};
      end else if (paddr >= `TCA_OFS_EN0 && paddr <= `TCA_OFS_EN4 && paddr[1:0] == 2'h0) begin
        k = int'(paddr[7:2]) - 1;
        for (int b = 0; b < 8; b++) begin
          rv[b] = en_r[k * 8 + b];
        end
        prdata_nxt = {24'h00_0000, rv};
      end else if (paddr == `TCA_OFS_CSR) begin
        // RL6: reserved top bits
        prdata_nxt = {21'h00_0000, nmi_flag_r, ae_r, swe_r, svec_r};
      end else if (paddr == `TCA_OFS_BASE) begin
        prdata_nxt = {16'h0000, base_r};
      end else if (paddr == `TCA_OFS_STAT) begin
        prdata_nxt = {26'h000_0000, soft_pend_r, 1'b0, 4'(st_r)};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // Reads arm the sequenced bits with the value software saw
    if (rd_acc && paddr >= `TCA_OFS_EN0 && paddr <= `TCA_OFS_EN4 && paddr[1:0] == 2'h0) begin
      k = int'(paddr[7:2]) - 1;
      arm_nxt[k] = 1'b1;
      for (int b = 0; b < 8; b++) begin
        snap_nxt[k * 8 + b] = en_r[k * 8 + b];
      end
    end
    if (rd_acc && paddr == `TCA_OFS_CSR) begin
      carm_nxt = 1'b1;
      csnap_nxt = {nmi_flag_r, ae_r, swe_r};
    end
    if (wr_acc && paddr == `TCA_OFS_BLKLEN) begin
      blklen_nxt = pwdata[15:0];
    end
    if (wr_acc && paddr >= `TCA_OFS_EN0 && paddr <= `TCA_OFS_EN4 && paddr[1:0] == 2'h0) begin
      k = int'(paddr[7:2]) - 1;
      wv = pwdata[7:0];
      // RL4: bit follows the write only if it differs from what was read
      for (int b = 0; b < 8; b++) begin
        // RL25: otherwise the bit holds
        if (arm_r[k] && wv[b] != snap_r[k * 8 + b]) begin
          en_nxt[k * 8 + b] = wv[b];
        end
      end
      arm_nxt[k] = 1'b0;
    end
    if (wr_acc && paddr == `TCA_OFS_CSR) begin
      // RL7: NMI flag clears on 0 after a read of 1
      if (carm_r && csnap_r[2] && !pwdata[`TCA_CSR_NMI]) begin
        nmi_flag_nxt = 1'b0;
      end
      // RL9: address error flag clears the same way
      if (carm_r && csnap_r[1] && !pwdata[`TCA_CSR_AE]) begin
        ae_nxt = 1'b0;
      end
      // RL11: vector frozen while soft activation is enabled
      if (!swe_r) begin
        svec_nxt = pwdata[`TCA_CSR_VEC];
      end
      // RL10: setting is free, clearing needs a read of 1 first
      if (pwdata[`TCA_CSR_SWE]) begin
        swe_nxt = 1'b1;
        soft_pend_nxt = 1'b1;
      end else if (carm_r && csnap_r[0]) begin
        swe_nxt = 1'b0;
        soft_pend_nxt = 1'b0;
      end
      carm_nxt = 1'b0;
    end
    // RL13: byte-lane writes leave the base untouched
    if (wr_acc && paddr == `TCA_OFS_BASE && full_word) begin
      base_nxt = pwdata[15:0];
    end
    // RL19: hardware clear of the enable when the CPU gets the interrupt
    en_nxt = en_nxt & ~ev_clr_en;
    // RL20: soft enable drops when no interrupt was raised
    if (ev_clr_swe) begin
      swe_nxt = 1'b0;
    end
    // Hardware sets win over a simultaneous software clear
    if (nmi_event) begin
      nmi_flag_nxt = 1'b1;
    end
    if (ev_set_ae) begin
      ae_nxt = 1'b1;
    end
    // RL3: standby entry wipes enables; RL5: and the control word
    if (stby_entry) begin
      en_nxt = `TCA_EN_RST;
      {nmi_flag_nxt, ae_nxt, swe_nxt, svec_nxt} = 11'(`TCA_CSR_RST);
      soft_pend_nxt = 1'b0;
    end
  end

  // Power-on reset clears control; manual reset is not wired here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= `TCA_EN_RST;
      {nmi_flag_r, ae_r, swe_r, svec_r} <= 11'(`TCA_CSR_RST);
      snap_r <= `TCA_EN_RST;
      arm_r <= 5'h00;
      csnap_r <= 3'h0;
      carm_r <= 1'b0;
      stby_q_r <= 1'b0;
      soft_pend_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      en_r <= en_nxt;
      {nmi_flag_r, ae_r, swe_r, svec_r} <= {nmi_flag_nxt, ae_nxt, swe_nxt, svec_nxt};
      snap_r <= snap_nxt;
      arm_r <= arm_nxt;
      csnap_r <= csnap_nxt;
      carm_r <= carm_nxt;
      stby_q_r <= standby;
      soft_pend_r <= soft_pend_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // RL14: base and block length kept through every reset, no init
  always_ff @(posedge pclk) begin
    base_r <= base_nxt;
    blklen_r <= blklen_nxt;
  end

  // ----------------------------------------------------------------
  // Descriptor engine
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] pk;
    logic [31:0] ns, nd;
    logic [7:0] lo;
    logic fire, nmi_abort, abort;
    pk = pick(pend_r);
    ns = sar_r;
    nd = dar_r;
    lo = 8'h00;
    fire = 1'b0;
    st_nxt = st_r;
    src_nxt = src_r;
    dsc_nxt = dsc_r;
    sar_nxt = sar_r;
    dar_nxt = dar_r;
    iar_nxt = iar_r;
    bst_nxt = bst_r;
    mw_nxt = mw_r;
    cnt_nxt = cnt_r;
    left_nxt = left_r;
    wi_nxt = wi_r;
    done_nxt = done_r;
    stop_nxt = stop_r || (nmi_event && st_r != tca_pkg::ST_IDLE);
    mem_req_nxt = mem_req;
    mem_we_nxt = mem_we;
    mem_size_nxt = mem_size;
    mem_addr_nxt = mem_addr;
    mem_wdata_nxt = mem_wdata;
    cpu_irq_nxt = 1'b0;
    cpu_irq_src_nxt = cpu_irq_src;
    ev_clr_en = `TCA_EN_RST;
    ev_clr_swe = 1'b0;
    ev_set_ae = 1'b0;
    ev_soft_taken = 1'b0;
    // RL21: every enabled request is latched until served or wiped by manual reset or standby entry
    pend_nxt = pend_r;
    for (int i = 0; i < `TCA_NSRC; i++) begin
      if (src_req[i] && en_r[en_bit(i)]) begin
        pend_nxt[i] = 1'b1;
      end
    end
    // RL24: abort at once unless the descriptor is fully read (past ST_DESC) and asks to continue
    nmi_abort = nmi_event && st_r != tca_pkg::ST_IDLE &&
                !(st_r != tca_pkg::ST_VEC && st_r != tca_pkg::ST_DESC && mw_r[`TCA_M_NMI_CONTINUE_MODE]);
    abort = nmi_abort || manual_reset || standby || (mem_req && mem_ack && mem_err);
    // Bus access requested from each access state, dropped on ack
    if (st_r != tca_pkg::ST_IDLE && !mem_req && !abort) begin
      mem_req_nxt = 1'b1;
    end
    unique case (st_r)
      tca_pkg::ST_IDLE: begin
        mem_req_nxt = 1'b0;
        stop_nxt = 1'b0;
        // RL7: no start while the NMI flag is set; RL9: nor address error
        if (!nmi_flag_r && !ae_r && !standby && !manual_reset) begin
          if (pk[6]) begin
            // RL22: two bytes per source in the vector table
            src_nxt = pk[5:0];
            pend_nxt[pk[5:0]] = 1'b0;
            mem_addr_nxt = {16'h0000, `TCA_VEC_BASE + {9'h000, pk[5:0], 1'b0}};
            st_nxt = tca_pkg::ST_VEC;
          end else if (soft_pend_r && swe_r) begin
            // RL12: soft vector added to the table base
            src_nxt = `TCA_SRC_SOFT;
            ev_soft_taken = 1'b1;
            mem_addr_nxt = {16'h0000, `TCA_VEC_BASE + {8'h00, svec_r}};
            st_nxt = tca_pkg::ST_VEC;
          end
          mem_we_nxt = 1'b0;
          mem_size_nxt = `TCA_SZ_WORD;
        end
      end
      tca_pkg::ST_VEC: begin
        if (mem_req && mem_ack) begin
          mem_req_nxt = 1'b0;
          // RL23: base gives the upper half, vector entry the lower
          dsc_nxt = {base_r, mem_rdata[15:0]};
          mem_addr_nxt = {base_r, mem_rdata[15:0]};
          mem_size_nxt = `TCA_SZ_LONG;
          wi_nxt = 2'h0;
          st_nxt = tca_pkg::ST_DESC;
        end
      end
      tca_pkg::ST_DESC: begin
        // RL15: descriptor words read in order: mode/count, src, dst, initial
        if (mem_req && mem_ack) begin
          mem_req_nxt = 1'b0;
          unique case (wi_r)
            2'h0: {mw_nxt, cnt_nxt} = mem_rdata;
            2'h1: sar_nxt = mem_rdata;
            2'h2: dar_nxt = mem_rdata;
            2'h3: iar_nxt = mem_rdata;
          endcase
          wi_nxt = wi_r + 2'h1;
          mem_addr_nxt = dsc_r + {28'h000_0000, wi_r + 2'h1, 2'h0};
          if (wi_r == `TCA_DESC_LAST) begin
            // RL1: block length of zero counts as 65536 units
            if (mw_r[`TCA_M_MD] == `TCA_MD_BLOCK) begin
              left_nxt = (blklen_r == 16'h0000) ? `TCA_LEN_FULL : {1'b0, blklen_r};
            end else begin
              left_nxt = 17'h0_0001;
            end
            bst_nxt = mw_r[`TCA_M_DTS] ? sar_r : dar_r;
            mem_addr_nxt = sar_r;
            mem_size_nxt = mw_r[`TCA_M_SZ];
            st_nxt = tca_pkg::ST_RD;
          end
        end
      end
      tca_pkg::ST_RD: begin
        if (mem_req && mem_ack) begin
          mem_req_nxt = 1'b0;
          mem_we_nxt = 1'b1;
          mem_addr_nxt = dar_r;
          mem_wdata_nxt = mem_rdata;
          st_nxt = tca_pkg::ST_WR;
        end
      end
      tca_pkg::ST_WR: begin
        if (mem_req && mem_ack) begin
          mem_req_nxt = 1'b0;
          // RL17: independent hold/increment/decrement of both addresses
          ns = step_addr(sar_r, mw_r[`TCA_M_SM], mw_r[`TCA_M_SZ]);
          nd = step_addr(dar_r, mw_r[`TCA_M_DM], mw_r[`TCA_M_SZ]);
          left_nxt = left_r - 17'h0_0001;
          if (left_r == 17'h0_0001) begin
            if (mw_r[`TCA_M_MD] == `TCA_MD_REPEAT) begin
              // Repeat area rewinds when the low count runs out
              lo = cnt_r[7:0] - 8'h01;
              done_nxt = 1'b0;
              if (cnt_r[7:0] == 8'h01) begin
                lo = cnt_r[15:8];
                if (mw_r[`TCA_M_DTS]) begin
                  ns = iar_r;
                end else begin
                  nd = iar_r;
                end
              end
              cnt_nxt = {cnt_r[15:8], lo};
            end else begin
              cnt_nxt = cnt_r - 16'h0001;
              done_nxt = (cnt_r == 16'h0001);
              // Block area returns to its start after each block
              if (mw_r[`TCA_M_MD] == `TCA_MD_BLOCK) begin
                if (mw_r[`TCA_M_DTS]) begin
                  ns = bst_r;
                end else begin
                  nd = bst_r;
                end
              end
            end
            wi_nxt = 2'h0;
            mem_addr_nxt = dsc_r;
            mem_size_nxt = `TCA_SZ_LONG;
            mem_wdata_nxt = {mw_r, cnt_nxt};
            st_nxt = tca_pkg::ST_WB;
          end else begin
            mem_we_nxt = 1'b0;
            mem_addr_nxt = ns;
            st_nxt = tca_pkg::ST_RD;
          end
          sar_nxt = ns;
          dar_nxt = nd;
        end
      end
      tca_pkg::ST_WB: begin
        // RL15: updated descriptor written back after the data moved
        if (mem_req && mem_ack) begin
          mem_req_nxt = 1'b0;
          wi_nxt = wi_r + 2'h1;
          mem_addr_nxt = dsc_r + {28'h000_0000, wi_r + 2'h1, 2'h0};
          mem_wdata_nxt = (wi_r == 2'h0) ? sar_r : dar_r;
          if (wi_r == `TCA_WB_LAST) begin
            mem_we_nxt = 1'b0;
            // RL16: chain to the descriptor sixteen bytes on
            // RL8: a pending NMI lets this one finish, then stops
            if (mw_r[`TCA_M_CHAIN_ENABLE] && !stop_nxt) begin
              dsc_nxt = dsc_r + `TCA_CHAIN_STEP;
              mem_addr_nxt = dsc_r + `TCA_CHAIN_STEP;
              wi_nxt = 2'h0;
              st_nxt = tca_pkg::ST_DESC;
            end else begin
              // RL18: interrupt every transfer, or only at count end
              fire = mw_r[`TCA_M_INTERRUPT_SELECT] || done_r;
              cpu_irq_nxt = fire;
              cpu_irq_src_nxt = src_r;
              if (src_r == `TCA_SRC_SOFT) begin
                ev_clr_swe = !fire;
              end else if (fire) begin
                ev_clr_en[en_bit(int'(src_r))] = 1'b1;
              end
              st_nxt = tca_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase
    // RL9: a bus error marks the flag and stops the engine
    if (mem_req && mem_ack && mem_err) begin
      ev_set_ae = 1'b1;
    end
    if (abort) begin
      st_nxt = tca_pkg::ST_IDLE;
      mem_req_nxt = 1'b0;
      mem_we_nxt = 1'b0;
      cpu_irq_nxt = 1'b0;
      ev_clr_en = `TCA_EN_RST;
      ev_clr_swe = 1'b0;
    end
    if (manual_reset || stby_entry) begin
      pend_nxt = `TCA_EN_RST;
    end
    busy_nxt = st_nxt != tca_pkg::ST_IDLE;
  end

  // Engine registers; descriptor copies need no reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= tca_pkg::ST_IDLE;
      src_r <= 6'h00;
      wi_r <= 2'h0;
      done_r <= 1'b0;
      stop_r <= 1'b0;
      mw_r <= 16'h0000;
      pend_r <= `TCA_EN_RST;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= 2'h0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      cpu_irq <= 1'b0;
      cpu_irq_src <= 6'h00;
      busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
      src_r <= src_nxt;
      wi_r <= wi_nxt;
      done_r <= done_nxt;
      stop_r <= stop_nxt;
      mw_r <= mw_nxt;
      pend_r <= pend_nxt;
      mem_req <= mem_req_nxt;
      mem_we <= mem_we_nxt;
      mem_size <= mem_size_nxt;
      mem_addr <= mem_addr_nxt;
      mem_wdata <= mem_wdata_nxt;
      cpu_irq <= cpu_irq_nxt;
      cpu_irq_src <= cpu_irq_src_nxt;
      busy <= busy_nxt;
    end
  end

  // Working copies of the descriptor
  always_ff @(posedge pclk) begin
    dsc_r <= dsc_nxt;
    sar_r <= sar_nxt;
    dar_r <= dar_nxt;
    iar_r <= iar_nxt;
    bst_r <= bst_nxt;
    cnt_r <= cnt_nxt;
    left_r <= left_nxt;
  end

endmodule

// ===== test/tca_monitor.sv
// Port checker for the transfer controller, bound to its top
// ----
// Checker
// ----
module tca_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic cpu_irq,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, quiet while reset is low
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_csr_zero: assert property (pready && !pwrite && paddr == 8'h18 |-> prdata[31:11] == 21'h0)
    else $error("reserved control bits not zero");
  a_en_width: assert property (pready && !pwrite && paddr inside {[8'h04:8'h14]} |-> prdata[31:8] == 24'h0)
    else $error("enable read wider than 8 bits");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request moved before ack");
  a_req_gap: assert property (mem_ack |=> !mem_req)
    else $error("no idle cycle after ack");
  a_irq_pulse: assert property (cpu_irq |=> !cpu_irq)
    else $error("interrupt pulse too long");
  a_err_idle: assert property (mem_ack && mem_err |-> ##[1:3] !busy)
    else $error("engine busy after address error");
  // Main scenarios seen
  c_irq: cover property (cpu_irq);
  c_err: cover property (mem_ack && mem_err);
  c_wr: cover property (pready && pwrite);
endmodule
bind tca_top tca_monitor mon (.*);

// ===== test/tca_mem_model.sv
// Behavioural system memory on the far side of the transfer bus
module tca_mem_model (
  input wire logic pclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic err_on,
  input wire logic [3:0] lat,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt = 4'h0;
  initial {mem_rdata, mem_ack, mem_err} = 34'h0;
  // Answer after lat cycles; data lines toggle outside the ack cycle
  always @(posedge pclk) begin
    mem_ack <= 1'h0;
    mem_err <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt == lat) begin
        cnt <= 4'h0;
        mem_ack <= 1'h1;
        mem_err <= err_on;
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
        if (mem_we) mem[mem_addr] = mem_wdata;
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== test/tca_top_tb.sv
// Directed bench for the transfer controller with a memory model
module tca_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic nmi_event = 1'h0, standby = 1'h0, manual_reset = 1'h0, err_on = 1'h0, slv_err;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rd, prdata, mem_addr, mem_wdata, mem_rdata;
  logic [3:0] pstrb = 4'hf, lat = 4'h0;
  logic [39:0] src_req = 40'h0;
  logic pready, pslverr, mem_req, mem_we, mem_ack, mem_err, cpu_irq, busy;
  logic [1:0] mem_size;
  logic [5:0] cpu_irq_src;
  int n_fail = 0, comparisons = 0;
  tca_top uut (.*);
  tca_mem_model mm (.*);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic fire(input logic [39:0] m);
    @(posedge pclk);
    src_req <= m;
    @(posedge pclk);
    src_req <= 40'h0;
  endtask
  // Engine needs two cycles to leave idle
  task automatic idle();
    int i = 0;
    repeat (3) @(posedge pclk);
    while (busy !== 1'h0 && i < 900) begin
      @(posedge pclk);
      i++;
    end
    chk("idle", 32'(busy), 32'h0);
  endtask
  task automatic wait_irq(input logic [5:0] s);
    int i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (cpu_irq !== 1'h1 && i < 900);
    chk("irq", 32'(cpu_irq), 32'h1);
    chk("irq src", 32'(cpu_irq_src), 32'(s));
  endtask
  task automatic desc(input logic [31:0] d, input logic [31:0] m, input logic [31:0] t);
    mm.mem[d] = m;
    mm.mem[d + 32'h4] = 32'h200;
    mm.mem[d + 32'h8] = t;
    mm.mem[d + 32'hc] = 32'h0;
  endtask
  task automatic t_reset();
    apb(1'h0, 8'h18, 32'h0);
    chk("csr", rd, 32'h0);
    apb(1'h0, 8'h24, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", 32'(slv_err), 32'h1);
    apb(1'h1, 8'h04, 32'h80);
    apb(1'h0, 8'h04, 32'h0);
    chk("en blind", rd, 32'h0);
    apb(1'h1, 8'h04, 32'hc0);
    apb(1'h0, 8'h04, 32'h0);
    chk("en set", rd, 32'hc0);
  endtask
  // Two sources at once, slow memory, nonzero base
  task automatic t_prio();
    mm.mem[32'h400] = 32'h0100;
    mm.mem[32'h402] = 32'h0140;
    mm.mem[32'h200] = 32'h5a;
    desc(32'h10100, 32'ha000_0001, 32'h300);
    desc(32'h10140, 32'ha000_0001, 32'h304);
    apb(1'h1, 8'h1c, 32'h1);
    lat <= 4'h3;
    fire(40'h3);
    wait_irq(6'h0);
    wait_irq(6'h1);
    chk("dst", 32'(mm.mem[32'h304][7:0]), 32'h5a);
    chk("src step", mm.mem[32'h10144], 32'h201);
    apb(1'h0, 8'h04, 32'h0);
    chk("en auto", rd, 32'h0);
  endtask
  task automatic t_soft();
    lat <= 4'h0;
    mm.mem[32'h410] = 32'h0180;
    desc(32'h10180, 32'ha000_0002, 32'h308);
    apb(1'h1, 8'h18, 32'h10);
    apb(1'h1, 8'h18, 32'h110);
    idle();
    apb(1'h0, 8'h18, 32'h0);
    chk("soft off", rd, 32'h10);
    chk("soft dst", 32'(mm.mem[32'h308][7:0]), 32'h5a);
    chk("wb", mm.mem[32'h10180], 32'ha000_0001);
  endtask
  task automatic t_nmi();
    @(posedge pclk);
    nmi_event <= 1'h1;
    @(posedge pclk);
    nmi_event <= 1'h0;
    apb(1'h0, 8'h04, 32'h0);
    apb(1'h1, 8'h04, 32'h80);
    fire(40'h1);
    repeat (20) @(posedge pclk);
    chk("blocked", mm.mem[32'h10100], 32'ha000_0000);
    apb(1'h0, 8'h18, 32'h0);
    chk("nmi", rd, 32'h410);
    apb(1'h1, 8'h18, 32'h10);
    apb(1'h0, 8'h18, 32'h0);
    chk("nmi clr", rd, 32'h10);
    idle();
  endtask
  task automatic t_err();
    err_on <= 1'h1;
    apb(1'h0, 8'h04, 32'h0);
    apb(1'h1, 8'h04, 32'h80);
    fire(40'h1);
    idle();
    err_on <= 1'h0;
    apb(1'h0, 8'h18, 32'h0);
    chk("ae", rd, 32'h210);
  endtask
  task automatic t_sby();
    manual_reset <= 1'h1;
    @(posedge pclk);
    manual_reset <= 1'h0;
    apb(1'h0, 8'h18, 32'h0);
    chk("csr kept", rd, 32'h210);
    standby <= 1'h1;
    @(posedge pclk);
    standby <= 1'h0;
    apb(1'h0, 8'h04, 32'h0);
    chk("en sby", rd, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk("csr sby", rd, 32'h0);
    apb(1'h0, 8'h1c, 32'h0);
    chk("base", rd, 32'h1);
  endtask
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #4 pclk = ~pclk;
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_prio();
    t_soft();
    t_nmi();
    t_err();
    t_sby();
    close_out();
  end
endmodule
